// ===== ssfl_consts.svh
// register offsets, field positions, reset values and limits of the status flag block
`ifndef SSFL_CONSTS_SVH
`define SSFL_CONSTS_SVH
`define SSFL_OFF_CTRL        12'h000
`define SSFL_OFF_VA_RANGE    12'h004
`define SSFL_OFF_ZV_RANGE    12'h008
`define SSFL_OFF_SPD_RATIO   12'h00c
`define SSFL_OFF_SPD_VALUE   12'h010
`define SSFL_OFF_ZSG_WIDTH   12'h014
`define SSFL_OFF_REV_STEPS   12'h018
`define SSFL_OFF_WRAP_RANGE  12'h01c
`define SSFL_OFF_WRAP_DIV    12'h020
`define SSFL_OFF_WRAP_WIDTH  12'h024
`define SSFL_OFF_STATUS      12'h028
`define SSFL_CTRL_VA_MODE_LO 0
`define SSFL_CTRL_SPD_TYPE   2
`define SSFL_CTRL_WRAP_EN    3
`define SSFL_CTRL_WRAP_SRC   4
`define SSFL_RST_VA_MODE     2'h2
`define SSFL_RST_VA_RANGE    32'h0000001e
`define SSFL_RST_ZV_RANGE    32'h0000000f
`define SSFL_RST_SPD_RATIO   32'h00000032
`define SSFL_RST_SPD_VALUE   32'h000003e8
`define SSFL_RST_ZSG_WIDTH   32'h00000012
`define SSFL_RST_REV_STEPS   32'h00002710
`define SSFL_RST_WRAP_RANGE  32'h00002710
`define SSFL_RST_WRAP_DIV    32'h00000001
`define SSFL_RST_WRAP_WIDTH  32'h0000000a
`define SSFL_MAX_VA_RANGE    32'h000000c8
`define SSFL_MAX_ZV_RANGE    32'h000000c8
`define SSFL_MAX_SPD_RATIO   32'h00000064
`define SSFL_MAX_SPD_VALUE   32'h003d0900
`define SSFL_MAX_ZSG_WIDTH   32'h00000708
`define SSFL_MAX_WRAP_DIV    32'h1fffffff
`define SSFL_MAX_WRAP_WIDTH  32'h00002710
`define SSFL_PERCENT_FULL    39'h0000000064
`define SSFL_TENTHS_PER_REV  32'h00000e10
`endif

// ===== ssfl_pkg.sv
// types shared by the status flag block
package ssfl_pkg;
  // serial divider states, gray along idle -> run -> done
  typedef enum logic [1:0] {
    SSFL_DIV_IDLE = 2'b00,
    SSFL_DIV_RUN  = 2'b01,
    SSFL_DIV_DONE = 2'b11
  } ssfl_div_st_t;
  // speed-attained judgment modes
  typedef enum logic [1:0] {
    SSFL_VA_FEEDBACK = 2'h0,
    SSFL_VA_COMMAND  = 2'h1,
    SSFL_VA_BOTH     = 2'h2
  } ssfl_va_mode_t;
endpackage : ssfl_pkg

// ===== ssfl_status_flags.sv
// servo operation-status and motor-position flag generator with ahb-lite settings
// What this block does
// - mode 0: feedback near command speed
// - mode 1: command speed equals target speed
// - mode 2: feedback near target speed
// - mode accepts 0..2, default 2, modes 1 and 2 internal only
// - attain range 1..200 r/min, default 30
// - torque-limiting flag when torque reaches limit
// - speed limiting clamps speed, flags at limit
// - ratio limit 1..100 percent, default 50
// - absolute limit 1..4000000 hz, default 1000
// - homing-done set by homing or preset
// - homing-done cleared at reset, operation start
// - zero-speed flag when speed within range
// - zero-speed range 0..200 r/min, default 15
// - overload warning at overload torque level
// - buffer-write flag while buffer being written
// - direct-ready when all run conditions hold
// - marker each revolution from preset point
// - marker width 1..1800 tenths degree, default 18
// - wrap-zero at wrap home when enabled
// - wrap range split into N intervals
// - wrap-zero width 1..10000 steps, default 10
// - wrap-zero source feedback or command position
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ssfl_consts.svh"
module ssfl_status_flags
  import ssfl_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // ahb-lite slave
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  // speed, torque and position inputs
  input  wire logic signed [31:0] fb_speed_rpm_i,
  input  wire logic signed [31:0] cmd_speed_rpm_i,
  input  wire logic signed [31:0] target_speed_rpm_i,
  input  wire logic               internal_profile_i,
  input  wire logic signed [31:0] cmd_speed_hz_i,
  input  wire logic        [31:0] op_speed_hz_i,
  input  wire logic signed [31:0] torque_i,
  input  wire logic        [31:0] torque_limit_i,
  input  wire logic               torque_limit_active_i,
  input  wire logic        [31:0] overload_torque_i,
  input  wire logic               speed_limit_request_i,
  input  wire logic signed [31:0] fb_pos_i,
  input  wire logic signed [31:0] cmd_pos_i,
  // driver state events and levels
  input  wire logic               fast_home_done_i,
  input  wire logic               home_done_i,
  input  wire logic               position_preset_i,
  input  wire logic               operation_start_i,
  input  wire logic               marker_preset_command_i,
  input  wire logic               buffer_writing_i,
  input  wire logic               control_power_on_i,
  input  wire logic               main_power_on_i,
  input  wire logic               excitation_cmd_i,
  input  wire logic               stop_input_i,
  input  wire logic               deviation_clear_input_i,
  input  wire logic               alarm_active_i,
  input  wire logic               homing_running_i,
  input  wire logic               maintenance_busy_i,
  // status flags
  output logic                    speed_attained_flag_o,
  output logic                    torque_limiting_flag_o,
  output logic                    speed_limiting_flag_o,
  output logic                    homing_done_flag_o,
  output logic                    zero_speed_flag_o,
  output logic                    overload_warning_flag_o,
  output logic                    direct_buffer_write_flag_o,
  output logic                    direct_ready_flag_o,
  output logic                    revolution_marker_o,
  output logic                    wrap_zero_output_o,
  output logic             [31:0] speed_clamped_hz_o
);

  // magnitude of a 33-bit signed value, used for every speed and torque test except the mode 1 command-equals-target compare
  function automatic logic [32:0] ssfl_abs(input logic signed [32:0] v);
    ssfl_abs = v[32] ? 33'(-v) : 33'(v);
  endfunction : ssfl_abs

  // settings writes outside the legal range are dropped so the old value stays
  function automatic logic ssfl_in_range(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
    ssfl_in_range = (v >= lo) && (v <= hi);
  endfunction : ssfl_in_range

  // ---------------- bus side ----------------
  logic        wr_pend_q;    // a write waits for its data phase
  logic [11:0] wr_addr_q;    // byte offset of that write
  logic [1:0]  va_mode_q;    // speed-attained judgment mode
  logic        spd_type_q;   // 0 ratio, 1 absolute value
  logic        wrap_en_q;    // wrap mode enable
  logic        wrap_src_q;   // 0 feedback, 1 command position
  logic [31:0] va_range_q;   // attain window, r/min
  logic [31:0] zv_range_q;   // zero-speed window, r/min
  logic [31:0] spd_ratio_q;  // limit percentage
  logic [31:0] spd_value_q;  // absolute limit, hz
  logic [31:0] zsg_width_q;  // marker width, tenths of a degree
  logic [31:0] rev_steps_q;  // steps in one revolution
  logic [31:0] wrap_range_q; // wrap range in steps
  logic [31:0] wrap_div_q;   // number of intervals
  logic [31:0] wrap_width_q; // wrap-zero width in steps
  logic        div_start_q;  // wrap geometry changed, recompute interval
  logic [31:0] status_w;     // live flag image for reads
  logic        addr_ok;      // address phase accepted

  assign addr_ok  = hsel_i && htrans_i[1] && hready_i;
  assign status_w = {22'h000000, wrap_zero_output_o, revolution_marker_o,
                     direct_ready_flag_o, direct_buffer_write_flag_o,
                     overload_warning_flag_o, zero_speed_flag_o, homing_done_flag_o,
                     speed_limiting_flag_o, torque_limiting_flag_o, speed_attained_flag_o};

  // zero wait state slave, always okay
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // read data is fetched in the address phase so it stands for the data phase
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h00000000;
    end else if (addr_ok && !hwrite_i) begin
      unique case ((haddr_i[31:12] == 20'h00000) ? haddr_i[11:0] : 12'hfff)
        `SSFL_OFF_CTRL:       hrdata_o <= {27'h0000000, wrap_src_q, wrap_en_q, spd_type_q,
                                           va_mode_q};
        `SSFL_OFF_VA_RANGE:   hrdata_o <= va_range_q;
        `SSFL_OFF_ZV_RANGE:   hrdata_o <= zv_range_q;
        `SSFL_OFF_SPD_RATIO:  hrdata_o <= spd_ratio_q;
        `SSFL_OFF_SPD_VALUE:  hrdata_o <= spd_value_q;
        `SSFL_OFF_ZSG_WIDTH:  hrdata_o <= zsg_width_q;
        `SSFL_OFF_REV_STEPS:  hrdata_o <= rev_steps_q;
        `SSFL_OFF_WRAP_RANGE: hrdata_o <= wrap_range_q;
        `SSFL_OFF_WRAP_DIV:   hrdata_o <= wrap_div_q;
        `SSFL_OFF_WRAP_WIDTH: hrdata_o <= wrap_width_q;
        `SSFL_OFF_STATUS:     hrdata_o <= status_w;
        default:              hrdata_o <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // write address is held until the data phase brings hwdata
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else if (hready_i) begin
      wr_pend_q <= addr_ok && hwrite_i && (haddr_i[31:12] == 20'h00000);
      wr_addr_q <= haddr_i[11:0];
    end
  end

  // settings registers; out-of-range values are ignored
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      va_mode_q    <= `SSFL_RST_VA_MODE;
      spd_type_q   <= 1'b0;
      wrap_en_q    <= 1'b0;
      wrap_src_q   <= 1'b0;
      va_range_q   <= `SSFL_RST_VA_RANGE;
      zv_range_q   <= `SSFL_RST_ZV_RANGE;
      spd_ratio_q  <= `SSFL_RST_SPD_RATIO;
      spd_value_q  <= `SSFL_RST_SPD_VALUE;
      zsg_width_q  <= `SSFL_RST_ZSG_WIDTH;
      rev_steps_q  <= `SSFL_RST_REV_STEPS;
      wrap_range_q <= `SSFL_RST_WRAP_RANGE;
      wrap_div_q   <= `SSFL_RST_WRAP_DIV;
      wrap_width_q <= `SSFL_RST_WRAP_WIDTH;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        `SSFL_OFF_CTRL: begin
          if (hwdata_i[1:0] != 2'h3) begin
            va_mode_q <= hwdata_i[1:0];
          end
          spd_type_q <= hwdata_i[`SSFL_CTRL_SPD_TYPE];
          wrap_en_q  <= hwdata_i[`SSFL_CTRL_WRAP_EN];
          wrap_src_q <= hwdata_i[`SSFL_CTRL_WRAP_SRC];
        end
        `SSFL_OFF_VA_RANGE: begin
          if (ssfl_in_range(hwdata_i, 32'h1, `SSFL_MAX_VA_RANGE)) va_range_q <= hwdata_i;
        end
        `SSFL_OFF_ZV_RANGE: begin
          if (ssfl_in_range(hwdata_i, 32'h0, `SSFL_MAX_ZV_RANGE)) zv_range_q <= hwdata_i;
        end
        `SSFL_OFF_SPD_RATIO: begin
          if (ssfl_in_range(hwdata_i, 32'h1, `SSFL_MAX_SPD_RATIO)) spd_ratio_q <= hwdata_i;
        end
        `SSFL_OFF_SPD_VALUE: begin
          if (ssfl_in_range(hwdata_i, 32'h1, `SSFL_MAX_SPD_VALUE)) spd_value_q <= hwdata_i;
        end
        `SSFL_OFF_ZSG_WIDTH: begin
          if (ssfl_in_range(hwdata_i, 32'h1, `SSFL_MAX_ZSG_WIDTH)) zsg_width_q <= hwdata_i;
        end
        `SSFL_OFF_REV_STEPS: begin
          if (hwdata_i != 32'h0) rev_steps_q <= hwdata_i;
        end
        `SSFL_OFF_WRAP_RANGE: begin
          if (hwdata_i != 32'h0) wrap_range_q <= hwdata_i;
        end
        `SSFL_OFF_WRAP_DIV: begin
          if (ssfl_in_range(hwdata_i, 32'h1, `SSFL_MAX_WRAP_DIV)) wrap_div_q <= hwdata_i;
        end
        `SSFL_OFF_WRAP_WIDTH: begin
          if (ssfl_in_range(hwdata_i, 32'h1, `SSFL_MAX_WRAP_WIDTH)) wrap_width_q <= hwdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------- wrap interval divider ----------------
  // a serial divider keeps a 32-bit combinational divide out of the timing path;
  // the wrap-zero output stays off for the 33 cycles a recompute takes
  ssfl_div_st_t div_st_q;
  logic [31:0]  div_quo_q;   // quotient being built
  logic [32:0]  div_rem_q;   // partial remainder
  logic [5:0]   div_cnt_q;   // bits left
  logic [31:0]  interval_q;  // steps per wrap interval
  logic [32:0]  div_trial;   // shifted remainder

  assign div_trial = {div_rem_q[31:0], div_quo_q[31]};

  // restart whenever the range or the division count is written
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_start_q <= 1'b1;
    end else begin
      div_start_q <= wr_pend_q && ((wr_addr_q == `SSFL_OFF_WRAP_RANGE) ||
                                   (wr_addr_q == `SSFL_OFF_WRAP_DIV));
    end
  end

  // one quotient bit per cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_st_q   <= SSFL_DIV_IDLE;
      div_quo_q  <= 32'h00000000;
      div_rem_q  <= 33'h000000000;
      div_cnt_q  <= 6'h00;
      interval_q <= `SSFL_RST_WRAP_RANGE;
    end else if (div_start_q) begin
      div_st_q  <= SSFL_DIV_RUN;
      div_quo_q <= wrap_range_q;
      div_rem_q <= 33'h000000000;
      div_cnt_q <= 6'h20;
    end else begin
      unique case (div_st_q)
        SSFL_DIV_IDLE: begin
        end
        SSFL_DIV_RUN: begin
          if (div_trial >= {1'b0, wrap_div_q}) begin
            div_rem_q <= div_trial - {1'b0, wrap_div_q};
            div_quo_q <= {div_quo_q[30:0], 1'b1};
          end else begin
            div_rem_q <= div_trial;
            div_quo_q <= {div_quo_q[30:0], 1'b0};
          end
          div_cnt_q <= div_cnt_q - 6'h01;
          if (div_cnt_q == 6'h01) div_st_q <= SSFL_DIV_DONE;
        end
        SSFL_DIV_DONE: begin
          interval_q <= (div_quo_q == 32'h0) ? 32'h00000001 : div_quo_q;
          div_st_q   <= SSFL_DIV_IDLE;
        end
        default: div_st_q <= SSFL_DIV_IDLE;
      endcase
    end
  end

  // ---------------- speed and torque flags ----------------
  logic [32:0] va_fb_cmd;   // |feedback - command|
  logic [32:0] va_fb_tgt;   // |feedback - target|
  logic [38:0] ratio_lim;   // operating speed times ratio / 100
  logic [38:0] limit_hz;    // active speed limit
  logic [32:0] cmd_hz_mag;  // commanded speed magnitude
  logic        at_limit;    // commanded speed at or above limit
  logic        va_now;      // speed-attained judgment this cycle

  assign va_fb_cmd  = ssfl_abs(33'(fb_speed_rpm_i) - 33'(cmd_speed_rpm_i));
  assign va_fb_tgt  = ssfl_abs(33'(fb_speed_rpm_i) - 33'(target_speed_rpm_i));
  assign ratio_lim  = (39'(op_speed_hz_i) * 39'(spd_ratio_q[6:0])) / `SSFL_PERCENT_FULL;
  assign limit_hz   = spd_type_q ? 39'(spd_value_q) : ratio_lim;
  assign cmd_hz_mag = ssfl_abs(33'(cmd_speed_hz_i));
  assign at_limit   = 39'(cmd_hz_mag) >= limit_hz;

  // modes 1 and 2 only mean something while the profile is made internally
  always_comb begin
    unique case (va_mode_q)
      SSFL_VA_COMMAND: va_now = internal_profile_i &&
                                (cmd_speed_rpm_i == target_speed_rpm_i);
      SSFL_VA_BOTH:    va_now = internal_profile_i &&
                                (va_fb_tgt <= 33'(va_range_q));
      default:         va_now = va_fb_cmd <= 33'(va_range_q);
    endcase
  end

  // level flags re-judged every cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      speed_attained_flag_o      <= 1'b0;
      torque_limiting_flag_o     <= 1'b0;
      speed_limiting_flag_o      <= 1'b0;
      zero_speed_flag_o          <= 1'b0;
      overload_warning_flag_o    <= 1'b0;
      direct_buffer_write_flag_o <= 1'b0;
      direct_ready_flag_o        <= 1'b0;
      speed_clamped_hz_o         <= 32'h00000000;
    end else begin
      speed_attained_flag_o   <= va_now;
      torque_limiting_flag_o  <= torque_limit_active_i &&
                                 (ssfl_abs(33'(torque_i)) >= 33'(torque_limit_i));
      speed_limiting_flag_o   <= speed_limit_request_i && at_limit;
      zero_speed_flag_o       <= ssfl_abs(33'(fb_speed_rpm_i)) <= 33'(zv_range_q);
      overload_warning_flag_o <= ssfl_abs(33'(torque_i)) >= 33'(overload_torque_i);
      direct_buffer_write_flag_o <= buffer_writing_i;
      direct_ready_flag_o     <= control_power_on_i && main_power_on_i && excitation_cmd_i &&
                                 !stop_input_i && !deviation_clear_input_i &&
                                 !alarm_active_i && !homing_running_i &&
                                 !maintenance_busy_i;
      // clamp the speed handed to the profile while limiting is requested
      if (speed_limit_request_i && at_limit) begin
        speed_clamped_hz_o <= limit_hz[31:0];
      end else begin
        speed_clamped_hz_o <= cmd_hz_mag[31:0];
      end
    end
  end

  // homing-done: completion sets, operation start clears, set wins a tie
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      homing_done_flag_o <= 1'b0;
    end else if (fast_home_done_i || home_done_i || position_preset_i) begin
      homing_done_flag_o <= 1'b1;
    end else if (operation_start_i) begin
      homing_done_flag_o <= 1'b0;
    end
  end

  // ---------------- position markers ----------------
  // phases follow position deltas; a move of under one revolution or interval
  // per cycle is assumed, which holds by far at any real motor speed
  logic               pos_seen_q;   // previous positions are valid
  logic signed [31:0] fb_prev_q;    // last feedback position
  logic signed [31:0] wsrc_prev_q;  // last wrap source position
  logic signed [32:0] rev_phase_q;  // position within one revolution
  logic signed [32:0] wrap_phase_q; // position within one wrap interval
  logic signed [31:0] wrap_src;     // selected wrap source
  logic signed [32:0] rev_sum;      // unwrapped revolution phase
  logic signed [32:0] wrap_sum;     // unwrapped interval phase
  logic signed [32:0] rev_next;     // wrapped revolution phase
  logic signed [32:0] wrap_next;    // wrapped interval phase

  assign wrap_src = wrap_src_q ? cmd_pos_i : fb_pos_i;
  assign rev_sum  = rev_phase_q + (33'(fb_pos_i) - 33'(fb_prev_q));
  assign wrap_sum = wrap_phase_q + (33'(wrap_src) - 33'(wsrc_prev_q));

  // fold the phases back into their ranges
  always_comb begin
    rev_next  = rev_sum;
    wrap_next = wrap_sum;
    if (rev_sum >= $signed({1'b0, rev_steps_q})) begin
      rev_next = rev_sum - $signed({1'b0, rev_steps_q});
    end else if (rev_sum < 0) begin
      rev_next = rev_sum + $signed({1'b0, rev_steps_q});
    end
    if (wrap_sum >= $signed({1'b0, interval_q})) begin
      wrap_next = wrap_sum - $signed({1'b0, interval_q});
    end else if (wrap_sum < 0) begin
      wrap_next = wrap_sum + $signed({1'b0, interval_q});
    end
  end

  // phase tracking; marker preset and position preset set the zero points
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_seen_q   <= 1'b0;
      fb_prev_q    <= 32'sh00000000;
      wsrc_prev_q  <= 32'sh00000000;
      rev_phase_q  <= 33'sh000000000;
      wrap_phase_q <= 33'sh000000000;
    end else begin
      pos_seen_q  <= 1'b1;
      fb_prev_q   <= fb_pos_i;
      wsrc_prev_q <= wrap_src;
      if (!pos_seen_q || marker_preset_command_i) begin
        rev_phase_q <= 33'sh000000000;
      end else begin
        rev_phase_q <= rev_next;
      end
      if (!pos_seen_q || position_preset_i || div_start_q) begin
        wrap_phase_q <= 33'sh000000000;
      end else begin
        wrap_phase_q <= wrap_next;
      end
    end
  end

  // marker on while phase * 3600 < width * steps per revolution
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      revolution_marker_o <= 1'b0;
      wrap_zero_output_o  <= 1'b0;
    end else begin
      revolution_marker_o <= pos_seen_q &&
        (64'(rev_phase_q[31:0]) * 64'(`SSFL_TENTHS_PER_REV) <
         64'(zsg_width_q) * 64'(rev_steps_q));
      wrap_zero_output_o  <= wrap_en_q && pos_seen_q && (div_st_q == SSFL_DIV_IDLE) &&
        (wrap_phase_q[31:0] < wrap_width_q);
    end
  end

endmodule : ssfl_status_flags

// ===== ssfl_status_chk.sv
// assertion checker for the servo status flag block
`timescale 1ns/1ps
module ssfl_status_chk (
  input wire logic               clk_i,
  input wire logic               rst_b_i,
  input wire logic               hreadyout_o,
  input wire logic               hresp_o,
  input wire logic signed [31:0] torque_i,
  input wire logic [31:0]        torque_limit_i,
  input wire logic               torque_limit_active_i,
  input wire logic [31:0]        overload_torque_i,
  input wire logic               fast_home_done_i,
  input wire logic               home_done_i,
  input wire logic               position_preset_i,
  input wire logic               operation_start_i,
  input wire logic               buffer_writing_i,
  input wire logic               torque_limiting_flag_o,
  input wire logic               homing_done_flag_o,
  input wire logic               overload_warning_flag_o,
  input wire logic               direct_buffer_write_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [31:0] mag; // torque magnitude, so reverse torque limits too
  logic        set; // any homing-done source this cycle
  assign mag = (torque_i < 0) ? -torque_i : torque_i;
  assign set = fast_home_done_i | home_done_i | position_preset_i;
  chk_torque_flag: assert property (rst_b_i |=> torque_limiting_flag_o ==
    $past(torque_limit_active_i && mag >= torque_limit_i)) else $error("torque flag wrong");
  chk_overload_level: assert property ($past(rst_b_i) |->
    overload_warning_flag_o == $past(mag >= overload_torque_i)) else $error("overload wrong");
  chk_buffer_flag: assert property ($past(rst_b_i) |->
    direct_buffer_write_flag_o == $past(buffer_writing_i)) else $error("buffer flag wrong");
  chk_homing_set: assert property (set |=> homing_done_flag_o)
    else $error("homing not set");
  chk_homing_clear: assert property (operation_start_i && !set |=> !homing_done_flag_o)
    else $error("homing not cleared");
  chk_homing_hold: assert property (!set && !operation_start_i |=> $stable(homing_done_flag_o))
    else $error("homing flag moved");
  chk_bus_ready: assert property ($past(rst_b_i) |-> hreadyout_o)
    else $error("bus not ready");
  chk_bus_okay: assert property (!hresp_o) else $error("bus response not okay");
endmodule : ssfl_status_chk

bind ssfl_status_flags ssfl_status_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .torque_i(torque_i),
  .torque_limit_i(torque_limit_i), .torque_limit_active_i(torque_limit_active_i),
  .overload_torque_i(overload_torque_i), .fast_home_done_i(fast_home_done_i),
  .home_done_i(home_done_i), .position_preset_i(position_preset_i),
  .operation_start_i(operation_start_i), .buffer_writing_i(buffer_writing_i),
  .torque_limiting_flag_o(torque_limiting_flag_o), .homing_done_flag_o(homing_done_flag_o),
  .overload_warning_flag_o(overload_warning_flag_o),
  .direct_buffer_write_flag_o(direct_buffer_write_flag_o));

// ===== ssfl_host_model.sv
// host motion model that moves the motor position
`timescale 1ns/1ps
module ssfl_host_model (
  input  wire logic               clk_i,
  input  wire logic               run_i,
  input  wire logic signed [31:0] step_i,
  output logic signed [31:0]      pos_o
);
  initial pos_o = 32'h0;
  // a slow profile so each marker pulse spans several cycles
  always @(posedge clk_i) begin
    if (run_i) begin
      pos_o <= pos_o + step_i;
    end
  end
endmodule : ssfl_host_model

// ===== servo_status_flag_logic_tb_top.sv
// self-checking testbench of the servo status flag block
`timescale 1ns/1ps
`include "ssfl_consts.svh"
module servo_status_flag_logic_tb_top;
  logic clk_i = 0, rst_b_i = 0, hsel = 0, hwrite = 0, hready, run = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, clamp;
  logic signed [31:0] fb = 0, cmd = 0, tgt = 0, chz = 0, trq = 0, step = 2, pos;
  logic [16:0] lv = 0; // level and pulse inputs of the driver state
  logic [9:0] fl; // flags in status register order
  int failures = 0, tests_run = 0, nm = 0, nw = 0;
  logic [31:0] rv [10] = '{32'(`SSFL_RST_VA_MODE), `SSFL_RST_VA_RANGE, `SSFL_RST_ZV_RANGE,
    `SSFL_RST_SPD_RATIO, `SSFL_RST_SPD_VALUE, `SSFL_RST_ZSG_WIDTH, `SSFL_RST_REV_STEPS,
    `SSFL_RST_WRAP_RANGE, `SSFL_RST_WRAP_DIV, `SSFL_RST_WRAP_WIDTH};
  always #2.5 clk_i = ~clk_i;
  ssfl_host_model host_u (.clk_i(clk_i), .run_i(run), .step_i(step), .pos_o(pos));
  ssfl_status_flags dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .fb_speed_rpm_i(fb),
    .cmd_speed_rpm_i(cmd), .target_speed_rpm_i(tgt), .internal_profile_i(lv[0]),
    .cmd_speed_hz_i(chz), .op_speed_hz_i(32'h3e8), .torque_i(trq), .torque_limit_i(32'h64),
    .torque_limit_active_i(lv[1]), .overload_torque_i(32'hc8), .speed_limit_request_i(lv[2]),
    .fb_pos_i(pos), .cmd_pos_i(pos), .fast_home_done_i(lv[3]), .home_done_i(lv[4]),
    .position_preset_i(lv[5]), .operation_start_i(lv[6]), .marker_preset_command_i(lv[7]),
    .buffer_writing_i(lv[8]), .control_power_on_i(lv[9]), .main_power_on_i(lv[10]),
    .excitation_cmd_i(lv[11]), .stop_input_i(lv[12]), .deviation_clear_input_i(lv[13]),
    .alarm_active_i(lv[14]), .homing_running_i(lv[15]), .maintenance_busy_i(lv[16]),
    .speed_attained_flag_o(fl[0]), .torque_limiting_flag_o(fl[1]),
    .speed_limiting_flag_o(fl[2]), .homing_done_flag_o(fl[3]), .zero_speed_flag_o(fl[4]),
    .overload_warning_flag_o(fl[5]), .direct_buffer_write_flag_o(fl[6]),
    .direct_ready_flag_o(fl[7]), .revolution_marker_o(fl[8]), .wrap_zero_output_o(fl[9]),
    .speed_clamped_hz_o(clamp));
  task automatic stop_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // bounded wait for the slave's ready, sampled before that edge's updates land
  task automatic hw;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 99);
    if (n >= 99) begin failures++; stop_test(); end
  endtask : hw
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= w;
    hw();
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    hw();
    rd = hrdata;
  endtask : bus
  task automatic ck(input int b, input logic e);
    repeat (2) @(posedge clk_i);
    #1 chk(32'(fl[b]), 32'(e));
    @(posedge clk_i);
  endtask : ck
  task automatic pulse(input logic [16:0] m);
    lv <= lv | m; @(posedge clk_i); lv <= lv & ~m;
  endtask : pulse
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1;
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin bus(0, 32'(i * 4), 0); chk(rd, rv[i]); end
    bus(0, 32'h1000, 0); chk(rd, 0);
    bus(1, 32'h4, 32'hc9); bus(0, 32'h4, 0); chk(rd, 32'h1e);
    bus(1, 32'h8, 0); fb <= 1; ck(4, 0); fb <= 0; ck(4, 1);
    lv <= 17'h1; tgt <= 1000; fb <= -970; ck(0, 0); fb <= 970; ck(0, 1);
    fb <= 1031; ck(0, 0); bus(1, 0, 0);
    cmd <= 1000; tgt <= 0; fb <= 1030; ck(0, 1); fb <= 969; ck(0, 0);
    bus(1, 0, 1); tgt <= 999; ck(0, 0); tgt <= 1000; ck(0, 1);
    bus(1, 0, 3); bus(0, 0, 0); chk(rd, 1);
    lv <= 17'h4; chz <= -500; ck(2, 1); chk(clamp, 500); chz <= 499; ck(2, 0);
    bus(1, 0, 4); chz <= 1000; ck(2, 1); chz <= 999; ck(2, 0);
    for (int b = 3; b < 6; b++) begin pulse(17'h40); ck(3, 0); pulse(17'h1 << b); ck(3, 1); end
    lv <= 17'h102; trq <= -100; ck(1, 1); chk(fl, 10'h14a); trq <= 200; ck(5, 1);
    for (int b = 9; b < 17; b++) begin lv <= 17'h00e00 ^ (17'h1 << b); ck(7, 0); end
    lv <= 17'h00e00; ck(7, 1);
    bus(1, 32'h18, 32'h3e8); bus(1, 32'h1c, 32'h3e8); bus(1, 32'h20, 4); bus(1, 0, 8);
    repeat (50) @(posedge clk_i);
    pulse(17'ha0); repeat (3) @(posedge clk_i);
    run <= 1; repeat (6) @(posedge clk_i);
    repeat (1002) begin @(posedge clk_i); #1 nm += 32'(fl[8] === 1'b1); nw += 32'(fl[9] === 1'b1); end
    chk(nm, 6); chk(nw, 40);
    stop_test();
  end
endmodule : servo_status_flag_logic_tb_top
